// file: cam_port.v
// Purpose: Parallel camera capture port with sync-pin or embedded-code framing and an 8-word receive queue
// Assumes: clock_i at 20 MHz, pixel clock well below 10 MHz, link inputs asynchronous to clock_i
// Notes:   Link inputs are oversampled by clock_i; pixel edges are found from the sampled pixel clock
`timescale 1ns/1ps
`include "cam_defs.vh"

// Function
// R1 - Capture mode 1 takes exactly one image, then stops taking pixels.
// R2 - Single mode reads 1 until image ends; then mode clears, done flag sets.
// R3 - Capture mode 2 captures images continuously; writing 0 stops it.
// R4 - Sync-pin mode starts on frame sync rising while line sync is high.
// R5 - A one-pixel-clock frame sync pulse is enough to start an image.
// R6 - In sync-pin mode pixels are valid only while line sync is high.
// R7 - In sync-pin mode the next frame sync rise ends the image.
// R8 - Embedded mode ignores sync pins, frames images by start and end codes.
// R9 - Software programs codes to match the sensor and never makes them equal.
// R10 - Data and sync inputs are sampled on the pixel clock rising edge.
// R11 - Sensor changes data on the pixel clock falling edge.
// R12 - 8-bit width uses low 8 inputs, four pixels per word, newest on top.
// R13 - Width select 1 gives 10-bit pixels, 2 gives 12-bit pixels.
// R14 - 10/12-bit pixels zero-extend to 16 bits, two per word, newest on top.
// R15 - Words enter a 32-bit by 8-word queue read through pixel_word_port.
// R16 - Level flag set while occupancy reaches the limit; interrupt when enabled.
// R17 - Full and has-data flags each have their own interrupt enable.
// R18 - DMA request while enabled, DMA on and a whole word is queued; the code waits for occupancy to reach the DMA threshold.
// R19 - Image end sets the done flag and interrupts when enabled.
// R20 - Done flag clears only by writing 1; writing 0 keeps it.
// R21 - Has-data flag clears itself once the queue is read empty.
// R22 - Capture needs interface enable; it then starts with the sensor unaided.
// R23 - DMA threshold sets the request level; 0 is invalid, resets to 1.
// R24 - DMA enable bit 1 allows requests; 0 blocks all requests.
// R25 - Word port read returns and removes the oldest word; link data synchronised.
// R26 - A word completed while the queue holds 8 is dropped.
module cam_port #(
  parameter DEPTH     = 8,
  parameter PTR_W     = 3
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_b_i,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [31:0] reg_rdata_o,
  // Sensor link
  input  wire        pix_clk_in_i,
  input  wire        frame_sync_in_i,
  input  wire        line_sync_in_i,
  input  wire [11:0] pix_data_in_i,
  // Requests
  output wire        irq_o,
  output wire        dma_req_o
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_WAIT   = 3'b010;
  localparam [2:0] ST_ACTIVE = 3'b100;
  localparam [PTR_W:0] DEPTH_W = DEPTH[PTR_W:0];

  // Register state
  reg [1:0]  mode_ff;
  reg [1:0]  width_ff;
  reg        emb_ff;
  reg [3:0]  level_lim_ff;
  reg [3:0]  dma_th_ff;
  reg        dma_en_ff;
  reg        enable_ff;
  reg [3:0]  ev_en_ff;
  reg        done_ff;
  reg [11:0] start_code_ff;
  reg [11:0] end_code_ff;
  reg [31:0] rdata_ff;
  reg        irq_ff;
  reg        dma_req_ff;

  // Link sampling
  reg [14:0] s1_ff;
  reg [14:0] s2_ff;
  reg [14:0] s3_ff;
  reg        pclk_lvl_ff;
  reg        fs_prev_ff;

  // Capture state
  reg [2:0]  state_ff;
  reg [31:0] pack_ff;
  reg [1:0]  pix_cnt_ff;

  // Queue
  reg [31:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wp_ff;
  reg [PTR_W-1:0] rp_ff;
  reg [PTR_W:0]   count_ff;

  wire        wr_cfg   = reg_wr_i && (reg_addr_i == `CAM_ADDR_CONFIG);
  wire        wr_en    = reg_wr_i && (reg_addr_i == `CAM_ADDR_ENABLES);
  wire        wr_fl    = reg_wr_i && (reg_addr_i == `CAM_ADDR_FLAGS);
  wire        wr_code  = reg_wr_i && (reg_addr_i == `CAM_ADDR_CODES);
  wire        rd_word  = reg_rd_i && (reg_addr_i == `CAM_ADDR_WORD_PORT);

  // Pixel edge: level flips to 1 once second and third stages agree high
  wire        pclk_rise = !pclk_lvl_ff && s2_ff[14] && s3_ff[14]; // [R10]
  wire        fs_now    = s3_ff[13];
  wire        ls_now    = s3_ff[12];
  wire [11:0] raw_data  = s3_ff[11:0];
  wire        fs_rise   = pclk_rise && fs_now && !fs_prev_ff; // [R5]

  // Pixel masked to the selected width
  reg  [11:0] pix_val;
  always @*
  begin
    case (width_ff)
      `CAM_WIDTH_8:  pix_val = {4'h0, raw_data[7:0]}; // [R12]
      `CAM_WIDTH_10: pix_val = {2'h0, raw_data[9:0]}; // [R13]
      default:       pix_val = raw_data; // [R13]
    endcase
  end

  wire        wide      = (width_ff != `CAM_WIDTH_8);
  wire        code_st   = pclk_rise && (pix_val == start_code_ff);
  wire        code_end  = pclk_rise && (pix_val == end_code_ff);
  wire        run_ok    = enable_ff && (mode_ff != `CAM_MODE_OFF); // [R22]
  wire        sync_start = fs_rise && ls_now; // [R4]

  // Capture sequencing
  reg  [2:0]  nxt_state;
  reg         img_end;
  reg         take_pix;
  always @*
  begin
    nxt_state = state_ff;
    img_end   = 1'b0;
    take_pix  = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (run_ok)
          nxt_state = ST_WAIT; // [R22]
      end
      ST_WAIT:
      begin
        if (!run_ok)
          nxt_state = ST_IDLE;
        else if (emb_ff ? code_st : sync_start) // [R8] [R4]
          nxt_state = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (!run_ok)
          nxt_state = ST_IDLE; // [R3]
        else if (emb_ff ? code_end : fs_rise)
        begin
          img_end = 1'b1; // [R7] [R8] [R19]
          if (mode_ff == `CAM_MODE_SINGLE)
            nxt_state = ST_IDLE; // [R1]
          else if (!emb_ff && ls_now)
            nxt_state = ST_ACTIVE; // [R3]
          else
            nxt_state = ST_WAIT; // [R3]
        end
        else if (pclk_rise && (emb_ff || ls_now))
          take_pix = 1'b1; // [R6] [R8]
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Packing: newest pixel shifts in at the top of the word
  wire [31:0] nxt_pack = wide ? {4'h0, pix_val, pack_ff[31:16]} // [R14]
                              : {pix_val[7:0], pack_ff[31:8]};   // [R12]
  wire        word_done = take_pix && (wide ? pix_cnt_ff[0] : (pix_cnt_ff == 2'h3));
  wire        q_full    = (count_ff == DEPTH_W);
  wire        q_empty   = (count_ff == {(PTR_W+1){1'b0}});
  wire        push      = word_done && !q_full; // [R26]
  wire        pop       = rd_word && !q_empty; // [R25]

  // Link synchroniser and pixel-edge tracking
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      s1_ff       <= 15'h0000;
      s2_ff       <= 15'h0000;
      s3_ff       <= 15'h0000;
      pclk_lvl_ff <= 1'b0;
      fs_prev_ff  <= 1'b0;
    end
    else
    begin
      s1_ff <= {pix_clk_in_i, frame_sync_in_i, line_sync_in_i, pix_data_in_i}; // [R25]
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff[14] == s3_ff[14])
        pclk_lvl_ff <= s3_ff[14];
      if (pclk_rise)
        fs_prev_ff <= fs_now; // [R10]
    end
  end

  // Capture state and packing registers
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      state_ff   <= ST_IDLE;
      pack_ff    <= 32'h0000_0000;
      pix_cnt_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (img_end || nxt_state != ST_ACTIVE || state_ff != ST_ACTIVE)
        pix_cnt_ff <= 2'h0; // Partial words of a finished image are dropped
      else if (take_pix)
      begin
        pack_ff    <= nxt_pack;
        pix_cnt_ff <= word_done ? 2'h0 : pix_cnt_ff + 2'h1;
      end
    end
  end

  // Receive queue storage
  always @(posedge clock_i)
  begin
    if (push)
      mem[wp_ff] <= nxt_pack; // [R15]
  end

  // Queue pointers and occupancy
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      wp_ff    <= {PTR_W{1'b0}};
      rp_ff    <= {PTR_W{1'b0}};
      count_ff <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + {{(PTR_W-1){1'b0}}, 1'b1};
      if (pop)
        rp_ff <= rp_ff + {{(PTR_W-1){1'b0}}, 1'b1}; // [R25]
      if (push && !pop)
        count_ff <= count_ff + {{PTR_W{1'b0}}, 1'b1};
      else if (pop && !push)
        count_ff <= count_ff - {{PTR_W{1'b0}}, 1'b1}; // [R21]
    end
  end

  // Configuration registers; hardware ends single mode
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      mode_ff       <= `CAM_MODE_OFF;
      width_ff      <= `CAM_WIDTH_8;
      emb_ff        <= 1'b0;
      level_lim_ff  <= `CAM_RST_LEVEL;
      dma_th_ff     <= `CAM_RST_DMATH; // [R23]
      dma_en_ff     <= 1'b0;
      enable_ff     <= 1'b0;
      ev_en_ff      <= 4'h0;
      start_code_ff <= 12'h000;
      end_code_ff   <= 12'h000;
    end
    else
    begin
      if (wr_cfg)
      begin
        width_ff     <= reg_wdata_i[`CAM_CFG_WIDTH_LSB+1:`CAM_CFG_WIDTH_LSB];
        emb_ff       <= reg_wdata_i[`CAM_CFG_EMB_BIT];
        level_lim_ff <= reg_wdata_i[`CAM_CFG_LEVEL_LSB+3:`CAM_CFG_LEVEL_LSB];
        dma_th_ff    <= reg_wdata_i[`CAM_CFG_DMATH_LSB+3:`CAM_CFG_DMATH_LSB];
        dma_en_ff    <= reg_wdata_i[`CAM_CFG_DMAEN_BIT]; // [R24]
        enable_ff    <= reg_wdata_i[`CAM_CFG_ENABLE_BIT];
      end
      if (img_end && mode_ff == `CAM_MODE_SINGLE)
        mode_ff <= `CAM_MODE_OFF; // [R2]
      else if (wr_cfg)
        mode_ff <= reg_wdata_i[`CAM_CFG_MODE_LSB+1:`CAM_CFG_MODE_LSB]; // [R1] [R3]
      if (wr_en)
        ev_en_ff <= reg_wdata_i[3:0];
      if (wr_code)
      begin
        start_code_ff <= reg_wdata_i[`CAM_CODE_START_LSB+11:`CAM_CODE_START_LSB];
        end_code_ff   <= reg_wdata_i[`CAM_CODE_END_LSB+11:`CAM_CODE_END_LSB];
      end
    end
  end

  // Live queue flags
  wire [3:0] lim_ext = level_lim_ff;
  wire [3:0] th_ext  = (dma_th_ff == 4'h0) ? 4'h1 : dma_th_ff; // [R23]
  wire [3:0] cnt_ext = count_ff;
  wire       fl_level = (cnt_ext >= lim_ext); // [R16]
  wire [3:0] flags    = {done_ff, !q_empty, q_full, fl_level}; // [R17] [R21]

  // Done flag: write-one-to-clear, a new image end wins over the clear
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
      done_ff <= 1'b0;
    else if (img_end)
      done_ff <= 1'b1; // [R2] [R19]
    else if (wr_fl && reg_wdata_i[`CAM_EV_DONE])
      done_ff <= 1'b0; // [R20]
  end

  // Register read mux
  reg [31:0] rd_mux;
  always @*
  begin
    case (reg_addr_i)
      `CAM_ADDR_VER:       rd_mux = `CAM_VERSION; // Arbitrary revision value
      `CAM_ADDR_FIFO_SIZE: rd_mux = {24'h000000, `CAM_FIFO_WORDS};
      `CAM_ADDR_CONFIG:    rd_mux = {enable_ff, 17'h00000, dma_en_ff, dma_th_ff, level_lim_ff,
                                     emb_ff, width_ff, mode_ff}; // [R2]
      `CAM_ADDR_ENABLES:   rd_mux = {28'h0000000, ev_en_ff};
      `CAM_ADDR_FLAGS:     rd_mux = {28'h0000000, flags};
      `CAM_ADDR_CODES:     rd_mux = {4'h0, end_code_ff, 4'h0, start_code_ff};
      `CAM_ADDR_WORD_PORT: rd_mux = q_empty ? 32'h0000_0000 : mem[rp_ff]; // [R25]
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data for one cycle, interrupt and DMA request outputs
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      rdata_ff   <= 32'h0000_0000;
      irq_ff     <= 1'b0;
      dma_req_ff <= 1'b0;
    end
    else
    begin
      rdata_ff   <= reg_rd_i ? rd_mux : 32'h0000_0000;
      irq_ff     <= |(flags & ev_en_ff); // [R16] [R17] [R19]
      dma_req_ff <= enable_ff && dma_en_ff && (cnt_ext >= th_ext) && !(pop && cnt_ext == th_ext); // [R18] [R24]
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign irq_o       = irq_ff;
  assign dma_req_o   = dma_req_ff;

endmodule

// file: cam_defs.vh
// Purpose: Register map, field positions and reset values for the camera capture port
// Assumes: 32-bit register words on byte addresses, 8-bit address port
// Notes:   Included by cam_port.v, the port monitor and the testbench
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH

// Register byte offsets
`define CAM_ADDR_VER        8'h00
`define CAM_ADDR_FIFO_SIZE  8'h04
`define CAM_ADDR_CONFIG     8'h08
`define CAM_ADDR_ENABLES    8'h0C
`define CAM_ADDR_FLAGS      8'h10
`define CAM_ADDR_CODES      8'h14
`define CAM_ADDR_WORD_PORT  8'h30

// capture_config field positions
`define CAM_CFG_MODE_LSB    0
`define CAM_CFG_WIDTH_LSB   2
`define CAM_CFG_EMB_BIT     4
`define CAM_CFG_LEVEL_LSB   5
`define CAM_CFG_DMATH_LSB   9
`define CAM_CFG_DMAEN_BIT   13
`define CAM_CFG_ENABLE_BIT  31

// event_flags / event_enables bit positions
`define CAM_EV_LEVEL        0
`define CAM_EV_FULL         1
`define CAM_EV_DATA         2
`define CAM_EV_DONE         3

// timing_code_values field positions
`define CAM_CODE_START_LSB  0
`define CAM_CODE_END_LSB    16

// Reset values and encodings
`define CAM_RST_DMATH       4'h1
`define CAM_RST_LEVEL       4'h1
`define CAM_MODE_OFF        2'h0
`define CAM_MODE_SINGLE     2'h1
`define CAM_MODE_CONT       2'h2
`define CAM_WIDTH_8         2'h0
`define CAM_WIDTH_10        2'h1
`define CAM_WIDTH_12        2'h2
`define CAM_VERSION         32'h0000_0101
`define CAM_FIFO_WORDS      8'h08

`endif

// file: cam_port_monitor.sv
// Purpose: Port checker for the camera capture port
// Assumes: Shadows follow software writes only
// Notes:   Bound to cam_port at the foot of this file
`timescale 1ns/1ps
`include "cam_defs.vh"
module cam_port_monitor (
  // Clock, reset and register port
  input wire        clock_i,
  input wire        rst_b_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // Link and requests
  input wire        pix_clk_in_i,
  input wire        frame_sync_in_i,
  input wire        line_sync_in_i,
  input wire [11:0] pix_data_in_i,
  input wire        irq_o,
  input wire        dma_req_o
);
  reg [31:0] cfg_ff;
  reg [3:0]  ena_ff;
  // Shadows of configuration and enables
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cfg_ff <= 32'h0000_0220;
      ena_ff <= 4'h0;
    end
    else if (reg_wr_i && reg_addr_i == `CAM_ADDR_CONFIG)
      cfg_ff <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == `CAM_ADDR_ENABLES)
      ena_ff <= reg_wdata_i[3:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_size_read: assert property (reg_rd_i && reg_addr_i == `CAM_ADDR_FIFO_SIZE |=> reg_rdata_o == 32'h8)
    else $error("queue size reads wrong");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_dma_gated: assert property (!cfg_ff[13] [*2] |-> !dma_req_o)
    else $error("dma request while dma off");
  a_dma_needs_enable: assert property (!cfg_ff[31] [*2] |-> !dma_req_o)
    else $error("dma request while port off");
  a_irq_masked: assert property (ena_ff == 4'h0 [*2] |-> !irq_o)
    else $error("interrupt with all enables clear");
  a_enables_read: assert property (reg_rd_i && reg_addr_i == `CAM_ADDR_ENABLES |=> reg_rdata_o[3:0] == ena_ff)
    else $error("enables read back wrong");
  a_config_read: assert property (reg_rd_i && reg_addr_i == `CAM_ADDR_CONFIG
    |=> {reg_rdata_o[31], reg_rdata_o[13:2]} == {cfg_ff[31], cfg_ff[13:2]})
    else $error("configuration read back wrong");
endmodule
bind cam_port cam_port_monitor i_mon (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .pix_clk_in_i(pix_clk_in_i), .frame_sync_in_i(frame_sync_in_i), .line_sync_in_i(line_sync_in_i),
  .pix_data_in_i(pix_data_in_i), .irq_o(irq_o), .dma_req_o(dma_req_o));

// file: cam_sensor_model.sv
// Purpose: Behavioural image sensor driving the link
// Assumes: Pixel period of 400 ns
// Notes:   Clock stands low between pixels called for
`timescale 1ns/1ps
module cam_sensor_model (
  // Link toward the port
  output logic        pix_clk_o,
  output logic        frame_sync_o,
  output logic        line_sync_o,
  output logic [11:0] pix_data_o
);
  // Idle link
  initial
  begin
    pix_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    line_sync_o = 1'b0;
    pix_data_o = 12'hA5A;
  end
  // One pixel: change at the falling edge, hold across the rising edge
  task automatic pix(input logic [11:0] d, input logic fs, input logic ls);
  begin
    pix_data_o = d;
    frame_sync_o = fs;
    line_sync_o = ls;
    #200 pix_clk_o = 1'b1;
    #200 pix_clk_o = 1'b0;
    pix_data_o = ~d;
    frame_sync_o = 1'b0;
    line_sync_o = 1'b0;
  end
  endtask
endmodule

// file: cam_port_tb.sv
// Purpose: Self-checking bench for the camera capture port
// Assumes: Sensor model drives the link, bench drives registers
// Notes:   Expected words are packed here from the sent pixels
`timescale 1ns/1ps
`include "cam_defs.vh"
module cam_port_tb;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  wire  [31:0] reg_rdata_o;
  wire         pclk, fsync, lsync, irq_o, dma_req_o;
  wire  [11:0] pdata;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cnt;
  logic [31:0] rv, acc;
  logic [11:0] px;
  logic [1:0]  w;
  logic [31:0] expq[$];
  // Clock
  always #25 clock_i = ~clock_i;
  cam_port i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pix_clk_in_i(pclk),
    .frame_sync_in_i(fsync), .line_sync_in_i(lsync), .pix_data_in_i(pdata), .irq_o(irq_o), .dma_req_o(dma_req_o));
  cam_sensor_model i_sen (.pix_clk_o(pclk), .frame_sync_o(fsync), .line_sync_o(lsync), .pix_data_o(pdata));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // Register write and read cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
  begin
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, reg_rdata_o, exp);
  end
  endtask
  // Random pixel, packed into the expected word when kept
  task automatic dpix(input logic fs, input logic ls, input bit keep);
  begin
    px = 12'($urandom) & 12'hCFF;
    i_sen.pix(px, fs, ls);
    if (keep)
    begin
      acc = (w == 2'h0) ? {px[7:0], acc[31:8]} : {4'h0, (w == 2'h1) ? {2'h0, px[9:0]} : px, acc[31:16]};
      cnt++;
      if (cnt == ((w == 2'h0) ? 4 : 2))
      begin
        if (expq.size() < 8)
          expq.push_back(acc);
        cnt = 0;
      end
    end
  end
  endtask
  // One image; in sync mode pixel 3 has line sync low
  task automatic frame(input bit emb, input int n, input bit keep);
  begin
    cnt = 0;
    // Lead-in pixel with frame sync low, so the start pulse is a fresh rise
    i_sen.pix(12'h000, 1'b0, 1'b0);
    i_sen.pix(emb ? 12'h3F0 : 12'h000, emb ? 1'($urandom) : 1'b1, emb ? 1'($urandom) : 1'b1);
    for (int i = 0; i < n; i++)
      dpix(emb ? 1'($urandom) : 1'b0, emb ? 1'($urandom) : (i != 3), keep && (emb || i != 3));
    i_sen.pix(emb ? 12'h3F1 : 12'h000, emb ? 1'($urandom) : 1'b1, 1'b0);
    repeat (10) @(posedge clock_i);
    #1;
  end
  endtask
  // Read all expected words, then an empty read
  task automatic drain;
  begin
    while (expq.size() > 0)
      rchk("word", `CAM_ADDR_WORD_PORT, expq.pop_front());
    rchk("empty word", `CAM_ADDR_WORD_PORT, 32'h0);
  end
  endtask
  task automatic end_of_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h1378702D));
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rchk("size", `CAM_ADDR_FIFO_SIZE, 32'h0000_0008);
    rchk("version", `CAM_ADDR_VER, `CAM_VERSION);
    rchk("config", `CAM_ADDR_CONFIG, 32'h0000_0220);
    rchk("flags", `CAM_ADDR_FLAGS, 32'h0);
    rchk("enables", `CAM_ADDR_ENABLES, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    $display("test reset values done");
    w = 2'h0;
    wr(`CAM_ADDR_ENABLES, 32'h0000_0008);
    wr(`CAM_ADDR_CONFIG, 32'h8000_2221);
    rchk("mode before", `CAM_ADDR_CONFIG, 32'h8000_2221);
    frame(1'b0, 9, 1'b1);
    chk("dma request", {31'h0, dma_req_o}, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    rchk("mode after", `CAM_ADDR_CONFIG, 32'h8000_2220);
    rchk("flags", `CAM_ADDR_FLAGS, 32'h0000_000D);
    drain;
    rchk("flags drained", `CAM_ADDR_FLAGS, 32'h8);
    chk("dma idle", {31'h0, dma_req_o}, 32'h0);
    wr(`CAM_ADDR_FLAGS, 32'h0);
    rchk("done kept", `CAM_ADDR_FLAGS, 32'h8);
    wr(`CAM_ADDR_FLAGS, 32'h8);
    rchk("done cleared", `CAM_ADDR_FLAGS, 32'h0);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    frame(1'b0, 5, 1'b0);
    rchk("single stopped", `CAM_ADDR_FLAGS, 32'h0);
    $display("test single image done");
    wr(`CAM_ADDR_CODES, 32'h03F1_03F0);
    rchk("codes", `CAM_ADDR_CODES, 32'h03F1_03F0);
    for (int k = 1; k < 3; k++)
    begin
      w = 2'(k);
      wr(`CAM_ADDR_CONFIG, 32'h8000_0232 | (32'(k) << 2));
      frame(1'b1, 4, 1'b1);
      frame(1'b1, 4, 1'b1);
      drain;
    end
    wr(`CAM_ADDR_CONFIG, 32'h8000_0230);
    frame(1'b1, 4, 1'b0);
    rchk("continuous stopped", `CAM_ADDR_FLAGS, 32'h8);
    $display("test embedded widths done");
    wr(`CAM_ADDR_FLAGS, 32'h8);
    w = 2'h0;
    wr(`CAM_ADDR_CONFIG, 32'h8000_3102);
    frame(1'b0, 40, 1'b1);
    chk("dma at threshold", {31'h0, dma_req_o}, 32'h1);
    rchk("full flags", `CAM_ADDR_FLAGS, 32'h0000_000F);
    drain;
    $display("test overflow done");
    end_of_test;
  end
endmodule
